/* File: rtl/sms_port.sv */
// byte-wide serial port, master or slave, with two-entry receive buffer
// Operation
// R1: master data write starts eight-bit shift
// R2: master stops clock, sets done after byte
// R3: done with interrupt enable raises interrupt
// R4: master never drives slave select itself
// R5: data exchanged on MOSI and MISO together
// R6: master continues or raises select after byte
// R7: slave idle, MISO released while select high
// R8: slave holds loaded data until select low
// R9: slave sets done after full byte
// R10: slave accepts writes before receive read
// R11: single buffered transmit, buffered receive
// R12: software reads byte before next completes
// R13: remote clock at most quarter core clock
// R14: enabled port overrides pin directions
// R15: slave active with select low, MISO optional
// R16: select high resets slave bit logic
// R17: master select output pin is general output
// R18: master select input must stay high
// R19: select low as master falls to slave
// R20: mode fault sets done, requests interrupt
// R21: software re-sets master after mode fault
// R22: bit order selects LSB or MSB first
// R23: rate bits divide clock, two to 128
// R24: polarity sets idle, phase sets sample edge
// R25: write during transfer sets collision flag
// R26: reset leaves port disabled, slave, flags clear
`timescale 1ns/1ps
`default_nettype none
`include "sms_params.svh"

module sms_port #(
  parameter int DEPTH = `SMS_FIFO_DEPTH,
  parameter int WIDTH = `SMS_DATA_WIDTH
) (
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     ctrl_wr_i,
  input  wire sms_pkg::sms_ctl_type     ctrl_i,
  input  wire sms_pkg::sms_dir_type     dir_i,
  input  wire logic                     global_irq_enable_i,
  input  wire logic                     irq_ack_i,
  input  wire logic                     status_rd_i,
  input  wire logic                     tx_valid_i,
  input  wire logic [WIDTH-1:0]         tx_data_i,
  output logic                          tx_ready_o,
  output logic                          rx_valid_o,
  input  wire logic                     rx_ready_i,
  output logic [WIDTH-1:0]              rx_data_o,
  output logic                          transfer_done_flag_o,
  output logic                          write_collision_flag_o,
  output logic                          master_select_o,
  output logic                          irq_o,
  input  wire sms_pkg::sms_pin_in_type  pin_i,
  output sms_pkg::sms_pin_out_type      pin_o
);
  import sms_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // whole module state
  typedef struct packed {
    sms_fsm_type               fsm;
    sms_ctl_type               ctl;
    sms_pin_in_type            pin_meta;
    sms_pin_in_type            pin_sync;
    logic                      sck_prev;
    logic [WIDTH-1:0]          shifter;
    logic                      out_bit;
    logic                      sck_out;
    logic [3:0]                edge_cnt;
    logic [3:0]                bit_cnt;
    logic [6:0]                div_cnt;
    logic                      done;
    logic                      write_collision_flag;
    logic                      done_arm;
    logic                      write_collision_flag_arm;
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]             count;
  } sms_state_type;

  sms_state_type state_reg;
  sms_state_type state_next;

  // first bit to go out, by bit order
  function automatic logic first_bit(input logic [WIDTH-1:0] sh,
                                     input logic lsb_first);
    first_bit = lsb_first ? sh[0] : sh[WIDTH-1];
  endfunction : first_bit

  // shift one received bit in, by bit order
  function automatic logic [WIDTH-1:0] shift_in(
      input logic [WIDTH-1:0] sh, input logic in_bit,
      input logic lsb_first);
    shift_in = lsb_first ? {in_bit, sh[WIDTH-1:1]}
                         : {sh[WIDTH-2:0], in_bit};
  endfunction : shift_in

  logic       is_master;
  logic       slave_on;
  logic       busy;
  logic       fifo_full;
  logic       mode_fault;
  logic       lead_edge;
  logic       trail_edge;
  logic [6:0] half_cnt;

  // derived conditions from registered state and the direction input
  always_comb begin
    is_master  = state_reg.ctl.port_enable & state_reg.ctl.master_select;
    slave_on   = state_reg.ctl.port_enable & ~state_reg.ctl.master_select
                 & ~state_reg.pin_sync.ss_n;
    fifo_full  = (state_reg.count == CW'(DEPTH));
    busy       = (state_reg.fsm != SMS_IDLE)
                 | (slave_on & (state_reg.bit_cnt != 4'd0));
    // a low select input while master means another master took the bus
    mode_fault = is_master & ~dir_i.ss_out & ~state_reg.pin_sync.ss_n; // R19
    lead_edge  = (state_reg.pin_sync.sck != state_reg.ctl.clock_polarity)
                 & (state_reg.sck_prev == state_reg.ctl.clock_polarity);
    trail_edge = (state_reg.pin_sync.sck == state_reg.ctl.clock_polarity)
                 & (state_reg.sck_prev != state_reg.ctl.clock_polarity);
    // half period from the rate bits
    case ({state_reg.ctl.double_rate, state_reg.ctl.rate_select_hi,
           state_reg.ctl.rate_select_lo})
      3'b000:  half_cnt = `SMS_HALF_DIV4;   // R23
      3'b001:  half_cnt = `SMS_HALF_DIV16;
      3'b010:  half_cnt = `SMS_HALF_DIV64;
      3'b011:  half_cnt = `SMS_HALF_DIV128;
      3'b100:  half_cnt = `SMS_HALF_DIV2;
      3'b101:  half_cnt = `SMS_HALF_DIV8;
      3'b110:  half_cnt = `SMS_HALF_DIV32;
      3'b111:  half_cnt = `SMS_HALF_DIV64;
      default: half_cnt = `SMS_HALF_DIV4;
    endcase
  end

  logic             push;
  logic             pop;
  logic             sample;
  logic             lsb;
  logic [WIDTH-1:0] rx_byte;

  // next-state logic
  always_comb begin
    state_next = state_reg;
    push       = 1'b0;
    pop        = rx_ready_i & (state_reg.count != '0);
    sample     = 1'b0;
    lsb        = state_reg.ctl.bit_order_select; // R22
    rx_byte    = state_reg.shifter;

    // pins pass two flops before any use
    state_next.pin_meta = pin_i;
    state_next.pin_sync = state_reg.pin_meta;
    state_next.sck_prev = state_reg.pin_sync.sck;

    // status read arms the clear, next data access performs it
    if (status_rd_i) begin
      state_next.done_arm = state_reg.done;
      state_next.write_collision_flag_arm = state_reg.write_collision_flag;
    end
    if (tx_valid_i | rx_ready_i) begin
      if (state_reg.done_arm | state_reg.write_collision_flag_arm) begin
        state_next.done = 1'b0; // R25
        state_next.write_collision_flag = 1'b0;
      end
      state_next.done_arm = 1'b0;
      state_next.write_collision_flag_arm = 1'b0;
    end
    if (irq_ack_i) begin
      state_next.done = 1'b0;
    end

    if (ctrl_wr_i) begin
      state_next.ctl = ctrl_i;
    end

    // data write: loads only when no shift is running
    if (tx_valid_i) begin
      if (busy) begin
        state_next.write_collision_flag = 1'b1; // R25 R11
      end else begin
        state_next.shifter = tx_data_i; // R8 R10
        state_next.out_bit = first_bit(tx_data_i, lsb);
        if (is_master) begin
          state_next.fsm = SMS_LOAD; // R1
        end
      end
    end

    case (state_reg.fsm)
      SMS_IDLE: begin
        state_next.sck_out  = state_reg.ctl.clock_polarity; // R24
        state_next.div_cnt  = 7'd0;
        state_next.edge_cnt = 4'd0;
      end
      // waits for receive room so a finished byte is never dropped
      SMS_LOAD: begin
        if (!fifo_full) begin
          state_next.fsm = SMS_XFER;
        end
      end
      SMS_XFER: begin
        if (state_reg.div_cnt == half_cnt - 7'd1) begin
          state_next.div_cnt = 7'd0;
          state_next.sck_out = ~state_reg.sck_out;
          // even edges lead; phase picks sample or setup
          sample = ~state_reg.edge_cnt[0] ^ state_reg.ctl.clock_phase;
          if (sample) begin
            state_next.shifter = shift_in(state_reg.shifter,
                                          state_reg.pin_sync.miso, lsb); // R5
          end else begin
            state_next.out_bit = first_bit(state_reg.shifter, lsb);
          end
          if (state_reg.edge_cnt == `SMS_LAST_EDGE) begin
            state_next.fsm  = SMS_IDLE; // R2
            state_next.done = 1'b1;
            push    = 1'b1;
            rx_byte = state_next.shifter;
          end else begin
            state_next.edge_cnt = state_reg.edge_cnt + 4'd1;
          end
        end else begin
          state_next.div_cnt = state_reg.div_cnt + 7'd1;
        end
      end
      default: begin
        state_next.fsm = SMS_IDLE;
      end
    endcase

    // slave engine runs on edges of the sampled remote clock
    if (!is_master) begin
      if (!slave_on) begin
        state_next.bit_cnt = 4'd0; // R16 R7
        if (!tx_valid_i) begin
          state_next.out_bit = first_bit(state_reg.shifter, lsb);
        end
      end else if (lead_edge | trail_edge) begin
        sample = lead_edge ^ state_reg.ctl.clock_phase; // R24
        if (sample) begin
          state_next.shifter = shift_in(state_reg.shifter,
                                        state_reg.pin_sync.mosi, lsb); // R5
          if (state_reg.bit_cnt == `SMS_BYTE_BITS - 4'd1) begin
            state_next.bit_cnt = 4'd0;
            state_next.done    = 1'b1; // R9
            push    = 1'b1;
            rx_byte = state_next.shifter;
          end else begin
            state_next.bit_cnt = state_reg.bit_cnt + 4'd1;
          end
        end else begin
          state_next.out_bit = first_bit(state_reg.shifter, lsb);
        end
      end
    end

    // mode fault: drop to slave and flag it
    if (mode_fault) begin
      state_next.ctl.master_select = 1'b0; // R19
      state_next.done = 1'b1; // R20
      state_next.fsm  = SMS_IDLE;
    end
    if (!state_reg.ctl.port_enable) begin
      state_next.fsm = SMS_IDLE;
    end

    // receive buffer: head in entry 0; a full buffer keeps the newest
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        state_next.mem[i] = state_reg.mem[i+1];
      end
      state_next.count = state_reg.count - CW'(1);
    end
    if (push) begin
      if (state_next.count == CW'(DEPTH)) begin
        state_next.mem[DEPTH-1] = rx_byte; // R12
      end else begin
        state_next.mem[state_next.count] = rx_byte; // R11
        state_next.count = state_next.count + CW'(1);
      end
    end
  end

  // state register; reset leaves the port off and in slave mode
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg          <= '0; // R26
      state_reg.fsm      <= SMS_IDLE;
      state_reg.pin_meta <= 4'hf;
      state_reg.pin_sync <= 4'hf;
    end else begin
      state_reg <= state_next;
    end
  end

  // software-side outputs
  always_comb begin
    tx_ready_o             = ~busy;
    rx_valid_o             = (state_reg.count != '0);
    rx_data_o              = state_reg.mem[0];
    transfer_done_flag_o   = state_reg.done;
    write_collision_flag_o = state_reg.write_collision_flag;
    master_select_o        = state_reg.ctl.master_select;
    irq_o = state_reg.done & state_reg.ctl.transfer_irq_enable
            & global_irq_enable_i; // R3 R20
  end

  // pin drive; select pin is never driven here, software owns it
  always_comb begin
    pin_o.sck     = state_reg.sck_out;
    pin_o.mosi    = state_reg.out_bit;
    pin_o.miso    = state_reg.out_bit;
    pin_o.sck_oe  = is_master & dir_i.sck_out;  // R14 R4 R17
    pin_o.mosi_oe = is_master & dir_i.mosi_out; // R14
    pin_o.miso_oe = slave_on & dir_i.miso_out;  // R15 R7
  end

endmodule : sms_port
`default_nettype wire

/* File: rtl/sms_params.svh */
// constants for the byte-wide serial master/slave port
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH

// half period of the generated serial clock, in core clock cycles,
// indexed by {double_rate, rate_select_hi, rate_select_lo}
`define SMS_HALF_DIV4   7'd2
`define SMS_HALF_DIV16  7'd8
`define SMS_HALF_DIV64  7'd32
`define SMS_HALF_DIV128 7'd64
`define SMS_HALF_DIV2   7'd1
`define SMS_HALF_DIV8   7'd4
`define SMS_HALF_DIV32  7'd16

// bits per byte and index of the last serial clock edge of a byte
`define SMS_BYTE_BITS   4'd8
`define SMS_LAST_EDGE   4'd15

// receive buffer shape
`define SMS_FIFO_DEPTH  2
`define SMS_DATA_WIDTH  8

`endif

/* File: rtl/sms_pkg.sv */
// types shared by the serial master/slave port
package sms_pkg;

  // transfer engine states, one-hot
  typedef enum logic [2:0] {
    SMS_IDLE = 3'b001,
    SMS_LOAD = 3'b010,
    SMS_XFER = 3'b100
  } sms_fsm_type;

  // control word written by software
  typedef struct packed {
    logic transfer_irq_enable;
    logic port_enable;
    logic bit_order_select;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic rate_select_hi;
    logic rate_select_lo;
    logic double_rate;
  } sms_ctl_type;

  // user-defined pin directions, 1 = output
  typedef struct packed {
    logic mosi_out;
    logic miso_out;
    logic sck_out;
    logic ss_out;
  } sms_dir_type;

  // pin levels seen from outside
  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
  } sms_pin_in_type;

  // pin drive, value and enable
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } sms_pin_out_type;

endpackage : sms_pkg

/* File: test/sms_props.sv */
// concurrent checks on the serial port's flags and pin drivers
`timescale 1ns/1ps
`default_nettype none
module sms_props #(
  parameter int WIDTH = 8
) (
  input wire logic                     clk_i,
  input wire logic                     arst_n_i,
  input wire logic                     ctrl_wr_i,
  input wire logic                     global_irq_enable_i,
  input wire logic                     tx_valid_i,
  input wire logic                     tx_ready_o,
  input wire logic                     rx_valid_o,
  input wire logic                     rx_ready_i,
  input wire logic [WIDTH-1:0]         rx_data_o,
  input wire logic                     transfer_done_flag_o,
  input wire logic                     write_collision_flag_o,
  input wire logic                     master_select_o,
  input wire logic                     irq_o,
  input wire sms_pkg::sms_pin_in_type  pin_i,
  input wire sms_pkg::sms_pin_out_type pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_irq_cause: assert property (
    irq_o |-> transfer_done_flag_o && global_irq_enable_i)
    else $error("interrupt without done flag");
  chk_reset_idle: assert property (
    $rose(arst_n_i) |-> !transfer_done_flag_o && !write_collision_flag_o
      && !master_select_o && !pin_o.miso_oe)
    else $error("port not idle after reset");
  chk_slave_quiet: assert property (
    (!master_select_o && pin_i.ss_n)[*3] |-> !pin_o.miso_oe)
    else $error("deselected slave drives miso");
  chk_master_miso: assert property (
    master_select_o |-> !pin_o.miso_oe)
    else $error("master drives miso");
  chk_slave_inputs: assert property (
    !master_select_o |-> !pin_o.mosi_oe && !pin_o.sck_oe)
    else $error("slave drives mosi or sck");
  chk_write_starts: assert property (
    tx_valid_i && tx_ready_o && master_select_o |=> !tx_ready_o)
    else $error("accepted write did not start a byte");
  chk_busy_collide: assert property (
    tx_valid_i && !tx_ready_o |=> write_collision_flag_o)
    else $error("busy write left no collision flag");
  chk_fault_done: assert property (
    $fell(master_select_o) && !$past(ctrl_wr_i) |-> transfer_done_flag_o)
    else $error("mode fault without done flag");
  chk_rx_hold: assert property (
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("receive head changed without a read");

  cov_master_done: cover property (master_select_o && $rose(irq_o));
  cov_mode_fault: cover property ($fell(master_select_o));
  cov_collision: cover property ($rose(write_collision_flag_o));
endmodule : sms_props

bind sms_port sms_props #(.WIDTH(WIDTH)) u_props (
  .clk_i, .arst_n_i, .ctrl_wr_i, .global_irq_enable_i, .tx_valid_i,
  .tx_ready_o, .rx_valid_o, .rx_ready_i, .rx_data_o, .transfer_done_flag_o,
  .write_collision_flag_o, .master_select_o, .irq_o, .pin_i, .pin_o);
`default_nettype wire

/* File: test/sms_far_slave.sv */
// far slave device answering the port while it is master
`timescale 1ns/1ps
`default_nettype none
module sms_far_slave (
  input  wire logic       sck_i,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  input  wire logic       mode_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  logic [2:0] cnt;
  logic       smp;
  logic       smp_q;
  logic       ss_q;
  // sample edge is the rising edge of sck once polarity and phase fold in
  assign smp = sck_i ^ mode_i;
  // one process owns every bit of the model but smp, so each has a single driver
  initial begin
    cnt    = 3'h0;
    miso_o = 1'b0;
    rx_o   = 8'h00;
    smp_q  = 1'b0;
    ss_q   = 1'b1;
    forever begin
      @(smp or ss_n_i);
      if (ss_q && !ss_n_i) begin
        // selection presents the first bit for leading-edge sampling
        cnt    = 3'h0;
        miso_o = tx_i[7];
      end else if (!ss_q && ss_n_i) begin
        // released line flips so a stale bit never looks valid
        miso_o = ~miso_o;
      end else if (!ss_n_i && smp && !smp_q) begin
        rx_o = {rx_o[6:0], mosi_i};
        cnt  = cnt + 3'h1;
      end else if (!ss_n_i && !smp && smp_q) begin
        miso_o = tx_i[3'h7 - cnt];
      end
      smp_q = smp;
      ss_q  = ss_n_i;
    end
  end
endmodule : sms_far_slave
`default_nettype wire

/* File: test/sms_port_tb_top.sv */
// self-checking bench for the serial master/slave port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) begin \
      mismatches++; \
      $display("wrong value at %0t: %h expected %h", $time, a, e); \
    end \
  end
module sms_port_tb_top;
  import sms_pkg::*;
  logic clk, arst_n, gie, ss_dev, ss_far, sck_m, mosi_m, far_miso;
  logic tx_ready, rx_valid, done, write_collision_flag, msel, irq;
  logic [4:0] strobe;
  logic [7:0] tx_data, rx_data, far_tx, far_rx, got, b;
  sms_ctl_type     ctrl;
  sms_dir_type     dir;
  sms_pin_in_type  pin_in;
  sms_pin_out_type pin_out;
  int m, cycles, mismatches, samples_checked;
  int waited;
  // rates stay at /8 or slower so the synchronised miso is never late
  logic [2:0] rate_tab [5] = '{3'b010, 3'b011, 3'b101, 3'b100, 3'b110};
  int         div_tab  [5] = '{16, 8, 32, 64, 128};
  // each shared wire follows whichever party enables its driver
  assign pin_in = {pin_out.sck_oe ? pin_out.sck : sck_m, ss_dev,
                   pin_out.mosi_oe ? pin_out.mosi : mosi_m,
                   pin_out.miso_oe ? pin_out.miso : far_miso};
  sms_port u_dut (
    .clk_i(clk), .arst_n_i(arst_n), .ctrl_wr_i(strobe[4]), .ctrl_i(ctrl),
    .dir_i(dir), .global_irq_enable_i(gie), .irq_ack_i(strobe[0]),
    .status_rd_i(strobe[1]), .tx_valid_i(strobe[3]), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_ready_i(strobe[2]),
    .rx_data_o(rx_data), .transfer_done_flag_o(done),
    .write_collision_flag_o(write_collision_flag), .master_select_o(msel), .irq_o(irq),
    .pin_i(pin_in), .pin_o(pin_out));
  sms_far_slave u_far (.sck_i(pin_in.sck), .ss_n_i(ss_far),
    .mosi_i(pin_in.mosi), .tx_i(far_tx), .miso_o(far_miso), .rx_o(far_rx),
    .mode_i(ctrl.clock_polarity ^ ctrl.clock_phase));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // runaway guard far beyond the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  function automatic logic [7:0] rev(input logic [7:0] v);
    return {<<{v}};
  endfunction : rev
  // one-cycle strobe: 0 ack, 1 status read, 2 pop, 3 data write, 4 control
  task automatic pulse(input int k, input logic [7:0] d);
    @(posedge clk);
    tx_data <= d;
    strobe <= 5'h01 << k;
    @(posedge clk);
    strobe <= 5'h00;
  endtask : pulse
  // counts negedges until done; bounded above the slowest byte
  task automatic wait_done();
    for (waited = 0; waited < 1100 && done !== 1'b1; waited++)
      @(negedge clk);
  endtask : wait_done
  // far master in mode 0, 200 ns per bit, miso taken at the rising edge
  task automatic send(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      mosi_m <= v[7-i];
      repeat (4) @(posedge clk);
      sck_m <= 1'b1;
      got = {got[6:0], pin_in.miso};
      repeat (4) @(posedge clk);
      sck_m <= 1'b0;
    end
  endtask : send
  task automatic end_sim();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    {arst_n, strobe, ctrl, dir, tx_data, far_tx, sck_m, mosi_m} = '0;
    {gie, ss_dev, ss_far} = 3'b111;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    `CHK({done, write_collision_flag, msel, pin_out.miso_oe}, 4'h0)
    // four clock modes at four rates, then one byte lsb first at the fifth
    for (m = 0; m < 5; m++) begin
      @(posedge clk);
      ctrl <= {1'b1, 1'b1, m == 4, 1'b1, m[1], m[0], rate_tab[m]};
      dir <= 4'b1010;
      far_tx <= 8'h5a ^ 8'(m);
      b = 8'hc3 + 8'(m);
      pulse(4, 8'h00);
      repeat (4) @(posedge clk);
      ss_far <= 1'b0;
      pulse(3, b);
      wait_done();
      `CHK(waited, 2 + 8 * div_tab[m])
      `CHK(far_rx, m == 4 ? rev(b) : b)
      `CHK(rx_data, m == 4 ? rev(far_tx) : far_tx)
      `CHK({irq, pin_out.sck}, {1'b1, m[1]})
      @(posedge clk);
      ss_far <= 1'b1;
      pulse(0, 8'h00);
      pulse(2, 8'h00);
      @(negedge clk);
      `CHK({done, rx_valid}, 2'b00)
    end
    // second write while busy is refused and flagged
    ss_far <= 1'b0;
    pulse(3, 8'h11);
    pulse(3, 8'h22);
    @(negedge clk);
    `CHK({write_collision_flag, tx_ready}, 2'b10)
    wait_done();
    `CHK(far_rx, rev(8'h11))
    pulse(1, 8'h00);
    pulse(2, 8'h00);
    @(negedge clk);
    `CHK({done, write_collision_flag}, 2'b00)
    // select pulled low by another master while select is an input
    @(posedge clk);
    ss_far <= 1'b1;
    ss_dev <= 1'b0;
    wait_done();
    `CHK({msel, pin_out.mosi_oe, pin_out.sck_oe}, 3'b000)
    `CHK({done, irq}, 2'b11)
    @(posedge clk);
    gie <= 1'b0;
    ss_dev <= 1'b1;
    @(negedge clk);
    `CHK(irq, 1'b0)
    pulse(0, 8'h00);
    // software takes the master role back after the fault
    pulse(4, 8'h00);
    @(negedge clk);
    `CHK(msel, 1'b1)
    // slave: load while deselected, clocks ignored until selected
    @(posedge clk);
    gie <= 1'b1;
    ctrl <= 9'h180;
    dir <= 4'b0100;
    pulse(4, 8'h00);
    pulse(3, 8'ha6);
    send(8'hff, 8);
    @(negedge clk);
    `CHK({done, rx_valid}, 2'b00)
    @(posedge clk);
    ss_dev <= 1'b0;
    repeat (2) @(posedge clk);
    send(8'h3c, 8);
    @(negedge clk);
    `CHK(got, 8'ha6)
    `CHK({done, irq, rx_data}, {2'b11, 8'h3c})
    pulse(3, 8'h81);
    send(8'h5b, 8);
    `CHK(got, 8'h81)
    // partial byte dropped by deselect, then overrun of a full buffer
    send(8'h00, 4);
    ss_dev <= 1'b1;
    repeat (8) @(posedge clk);
    ss_dev <= 1'b0;
    repeat (2) @(posedge clk);
    send(8'h99, 8);
    @(negedge clk);
    `CHK(rx_data, 8'h3c)
    pulse(2, 8'h00);
    @(negedge clk);
    `CHK(rx_data, 8'h99)
    pulse(2, 8'h00);
    @(negedge clk);
    `CHK(rx_valid, 1'b0)
    end_sim();
  end
endmodule : sms_port_tb_top
`default_nettype wire
